// *** asd_map.svh ***
/*
  Constants for the scan and setup command decoder: command byte fields,
  reset values and timing counts.
  Assumes a single 10 MHz core clock.
*/
// Overview of operation
// - MSB one means scan request; bit6 ignored
// - Bits 5..3 give channel number N
// - Mode 00 scans 0..N, 01 scans N..top
// - Mode 10 repeats N, count from averaging
// - Mode 11 converts N once only
// - Bit0 adds temperature as first result
// - Clock modes 10/11: write starts scan
// - Clock modes 00/01: low start pulse starts scan
// - Skip channels used as start or reference
// - Differential pair ignores lowest select bit
// - Bits 7:6 = 01 means setup write
// - Setup bits 5:4 clock mode, bit5 resets one
// - Modes 00/01 internal clock, shared pin start
// - Modes 10/11 shared pin is input seven
// - Setup bits 3:2 reference mode
// - Setup bits 1:0 select pairing register access
// - Reference held on in three cases
// - Held reference: temperature waits 188 cycles
// - Ref modes 01/11 second pin is reference
// - Temperature result first, newer overwrites older
`ifndef ASD_MAP_SVH
`define ASD_MAP_SVH
`define ASD_CMD_SEL_BIT      7
`define ASD_SETUP_SEL_BIT    6
`define ASD_CHAN_HI          5
`define ASD_CHAN_LO          3
`define ASD_SWEEP_HI         2
`define ASD_SWEEP_LO         1
`define ASD_TEMP_BIT         0
`define ASD_CLK_HI           5
`define ASD_CLK_LO           4
`define ASD_REF_HI           3
`define ASD_REF_LO           2
`define ASD_PAIR_HI          1
`define ASD_PAIR_LO          0
`define ASD_CLK_RESET        2'b10
`define ASD_REF_RESET        2'b10
`define ASD_TEMP_DELAY_CYC   188
`define ASD_REF_PIN_CHAN     3'h6
`define ASD_START_PIN_CHAN   3'h7
`endif

// *** asd_pkg.sv ***
/*
  Types for the scan and setup command decoder.
  Assumes asd_map.svh is included where fields are sliced.
*/
package asd_pkg;
  typedef enum logic [1:0] {
    ASD_SWEEP_LOW  = 2'b00,
    ASD_SWEEP_HIGH = 2'b01,
    ASD_SWEEP_REP  = 2'b10,
    ASD_SWEEP_ONE  = 2'b11
  } asd_sweep_t;

  typedef struct packed {
    logic [2:0] channel;
    asd_sweep_t sweep;
    logic       temp;
  } asd_scan_cfg_t;

  typedef struct packed {
    logic [1:0] clock_mode;
    logic [1:0] reference_mode;
  } asd_setup_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       temp;
    logic [2:0] channel;
  } asd_conv_t;
endpackage

// *** asd_delay.sv ***
/*
  Countdown used to hold off a temperature conversion while the reference
  is already on. Load restarts the count; done pulses once at the end.
  Assumes one core clock and an active low asynchronous reset.
*/
`timescale 1ns/100ps
module asd_delay #(
  parameter int CYCLES = 188
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic load,
  output logic      busy,
  output logic      done
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count;

  initial begin
    if (CYCLES < 1) $error("asd_delay: CYCLES must be at least one");
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        count <= W'(CYCLES - 1);
        busy  <= 1'b1;
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule // asd_delay

// *** asd_decoder.sv ***
/*
  Command byte decoder and scan sequencer for a multichannel ADC.
  Takes command bytes already assembled by the serial front end, holds the
  scan and setup fields, starts scans on a write or on a start pin pulse,
  and issues one conversion request at a time, held until the converter accepts it.
  Assumes cmd_valid is a one-cycle strobe; conv_ready is the converter's
  acceptance of the current request.
*/
`timescale 1ns/100ps
`include "asd_map.svh"
module asd_decoder
  import asd_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic     core_clk,
  input  wire logic     nrst,
  input  wire logic     cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic     conversion_start_pin_n,
  input  wire logic [3:0] pair_enable,
  input  wire logic [1:0] repeat_count,
  input  wire logic     reference_force_on,
  input  wire logic     dac_powered_up,
  input  wire logic     dac_parked_to_ref,
  input  wire logic     conv_ready,
  output asd_conv_t     conv_req,
  output asd_scan_cfg_t scan_cfg,
  output asd_setup_cfg_t setup_cfg,
  output logic [1:0]    pairing_select,
  output logic          pairing_access,
  output logic          start_pin_active,
  output logic          second_ref_active,
  output logic          reference_hold,
  output logic          scan_busy,
  output logic          temp_fresh
);
  typedef enum logic [2:0] {S_IDLE, S_TWAIT, S_TEMP, S_CONV, S_NEXT} asd_state_t;

  asd_state_t state;
  logic [2:0] chan;
  logic [2:0] last;
  logic [5:0] reps;
  logic       pin_q;
  logic       start;
  logic       dly_busy;
  logic       dly_done;
  logic       next_hold;

  initial begin
    if (CHANNELS != 4 && CHANNELS != 8) $error("asd_decoder: CHANNELS must be 4 or 8");
  end

  // Channel is skipped if its pin is taken or it is the odd half of a pair
  function automatic logic skip_chan(input logic [2:0] c, input asd_setup_cfg_t s,
                                     input logic [3:0] pairs);
    logic k;
    k = 1'b0;
    if (c == `ASD_START_PIN_CHAN && !s.clock_mode[1]) k = 1'b1;
    if (c == `ASD_REF_PIN_CHAN && s.reference_mode[0]) k = 1'b1;
    if (pairs[c[2:1]] && c[0]) k = 1'b1;
    return k;
  endfunction

  function automatic logic [2:0] pair_base(input logic [2:0] c, input logic [3:0] pairs);
    return pairs[c[2:1]] ? {c[2:1], 1'b0} : c;
  endfunction

  assign next_hold = reference_force_on
                   | ((dac_powered_up | dac_parked_to_ref) && setup_cfg.reference_mode == 2'b00);

  // Command decode and held fields
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scan_cfg                 <= '0;
      setup_cfg.clock_mode     <= `ASD_CLK_RESET;
      setup_cfg.reference_mode <= `ASD_REF_RESET;
      pairing_select           <= 2'b00;
      pairing_access           <= 1'b0;
    end else begin
      pairing_access <= 1'b0;
      if (cmd_valid && cmd_byte[`ASD_CMD_SEL_BIT]) begin
        scan_cfg.channel <= cmd_byte[`ASD_CHAN_HI:`ASD_CHAN_LO];
        scan_cfg.sweep   <= asd_sweep_t'(cmd_byte[`ASD_SWEEP_HI:`ASD_SWEEP_LO]);
        scan_cfg.temp    <= cmd_byte[`ASD_TEMP_BIT];
      end else if (cmd_valid && cmd_byte[`ASD_SETUP_SEL_BIT]) begin
        setup_cfg.clock_mode     <= cmd_byte[`ASD_CLK_HI:`ASD_CLK_LO];
        setup_cfg.reference_mode <= cmd_byte[`ASD_REF_HI:`ASD_REF_LO];
        pairing_select           <= cmd_byte[`ASD_PAIR_HI:`ASD_PAIR_LO];
        pairing_access           <= cmd_byte[`ASD_PAIR_HI:`ASD_PAIR_LO] != 2'b00;
      end
    end
  end

  // Pin roles and reference hold
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      start_pin_active  <= 1'b0;
      second_ref_active <= 1'b0;
      reference_hold    <= 1'b0;
    end else begin
      start_pin_active  <= !setup_cfg.clock_mode[1];
      second_ref_active <= setup_cfg.reference_mode[0];
      reference_hold    <= next_hold;
    end
  end

  // Start pulse edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= conversion_start_pin_n;
    end
  end

  assign start = (cmd_valid && cmd_byte[`ASD_CMD_SEL_BIT] && setup_cfg.clock_mode[1])
               || (!setup_cfg.clock_mode[1] && pin_q && !conversion_start_pin_n);

  asd_delay #(
    .CYCLES (`ASD_TEMP_DELAY_CYC)
  ) u_delay (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (state == S_IDLE && start && next_hold
               && (cmd_byte[`ASD_CMD_SEL_BIT] && cmd_valid ? cmd_byte[`ASD_TEMP_BIT] : scan_cfg.temp)),
    .busy     (dly_busy),
    .done     (dly_done)
  );

  // Scan sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state      <= S_IDLE;
      chan       <= 3'h0;
      last       <= 3'h0;
      reps       <= 6'h00;
      conv_req   <= '0;
      scan_busy  <= 1'b0;
      temp_fresh <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          conv_req <= '0;
          if (start) begin
            logic [2:0] n;
            logic [1:0] sw;
            logic       t;
            n  = (cmd_valid && cmd_byte[`ASD_CMD_SEL_BIT]) ? cmd_byte[`ASD_CHAN_HI:`ASD_CHAN_LO] : scan_cfg.channel;
            sw = (cmd_valid && cmd_byte[`ASD_CMD_SEL_BIT]) ? cmd_byte[`ASD_SWEEP_HI:`ASD_SWEEP_LO] : scan_cfg.sweep;
            t  = (cmd_valid && cmd_byte[`ASD_CMD_SEL_BIT]) ? cmd_byte[`ASD_TEMP_BIT] : scan_cfg.temp;
            scan_busy <= 1'b1;
            unique case (asd_sweep_t'(sw))
              ASD_SWEEP_LOW: begin
                chan <= 3'h0;
                last <= n;
              end
              ASD_SWEEP_HIGH: begin
                chan <= pair_base(n, pair_enable);
                last <= 3'(CHANNELS - 1);
              end
              ASD_SWEEP_REP: begin
                chan <= pair_base(n, pair_enable);
                last <= pair_base(n, pair_enable);
              end
              ASD_SWEEP_ONE: begin
                chan <= pair_base(n, pair_enable);
                last <= pair_base(n, pair_enable);
              end
            endcase
            // Six bits so that the largest repeat count of 32 still fits
            reps  <= (asd_sweep_t'(sw) == ASD_SWEEP_REP) ? 6'(4 << repeat_count) : 6'h01;
            state <= t ? (next_hold ? S_TWAIT : S_TEMP) : S_CONV;
          end
        end
        S_TWAIT: begin
          if (dly_done || !dly_busy) state <= S_TEMP;
        end
        S_TEMP: begin
          conv_req <= '{valid: 1'b1, temp: 1'b1, channel: 3'h0};
          if (conv_req.valid && conv_ready) begin
            conv_req   <= '0;
            temp_fresh <= 1'b1;
            state      <= S_CONV;
          end
        end
        S_CONV: begin
          temp_fresh <= 1'b0;
          if (skip_chan(chan, setup_cfg, pair_enable)) begin
            conv_req <= '0;
            state    <= S_NEXT;
          end else begin
            conv_req <= '{valid: 1'b1, temp: 1'b0, channel: chan};
            if (conv_req.valid && conv_ready) begin
              conv_req <= '0;
              state    <= S_NEXT;
            end
          end
        end
        S_NEXT: begin
          if (reps > 6'h01) begin
            reps  <= reps - 6'h01;
            state <= S_CONV;
          end else if (chan < last) begin
            chan  <= chan + 3'h1;
            state <= S_CONV;
          end else begin
            scan_busy <= 1'b0;
            state     <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule // asd_decoder

// *** asd_checker.sv ***
/*
  Port checker for the scan and setup command decoder.
  Assumes one core clock and an active low asynchronous reset.
*/
`timescale 1ns/100ps
module asd_checker
  import asd_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       conversion_start_pin_n,
  input wire logic       reference_force_on,
  input wire logic       dac_powered_up,
  input wire logic       dac_parked_to_ref,
  input wire logic       conv_ready,
  input asd_conv_t       conv_req,
  input asd_scan_cfg_t   scan_cfg,
  input asd_setup_cfg_t  setup_cfg,
  input wire logic       start_pin_active,
  input wire logic       second_ref_active,
  input wire logic       reference_hold,
  input wire logic       scan_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_scan_wr;
    cmd_valid && cmd_byte[7] |=> scan_cfg == $past(cmd_byte[5:0]);
  endproperty
  a_scan_wr: assert property (p_scan_wr) else $error("scan fields wrong");
  property p_setup_wr;
    cmd_valid && cmd_byte[7:6] == 2'b01 |=> setup_cfg == $past(cmd_byte[5:2]);
  endproperty
  a_setup_wr: assert property (p_setup_wr) else $error("setup fields wrong");
  property p_start_role;
    $stable(setup_cfg) |-> start_pin_active == !setup_cfg.clock_mode[1];
  endproperty
  a_start_role: assert property (p_start_role) else $error("start pin role wrong");
  property p_ref_role;
    $stable(setup_cfg) |-> second_ref_active == setup_cfg.reference_mode[0];
  endproperty
  a_ref_role: assert property (p_ref_role) else $error("reference pin role wrong");
  property p_hold;
    reference_hold == $past(reference_force_on
      || ((dac_powered_up || dac_parked_to_ref) && setup_cfg.reference_mode == 2'b00));
  endproperty
  a_hold: assert property (p_hold) else $error("reference hold wrong");
  property p_wr_start;
    cmd_valid && cmd_byte[7] && setup_cfg.clock_mode[1] && !scan_busy |=> scan_busy;
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write did not start scan");
  property p_pin_start;
    $fell(conversion_start_pin_n) && !setup_cfg.clock_mode[1] && !scan_busy |=> scan_busy;
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("pin did not start scan");
  property p_temp_first;
    $rose(scan_busy) && scan_cfg.temp && !reference_hold |=> conv_req.valid && conv_req.temp;
  endproperty
  a_temp_first: assert property (p_temp_first) else $error("temperature not first");
  property p_temp_wait;
    $rose(scan_busy) && scan_cfg.temp && reference_hold |=> !conv_req.valid [*8];
  endproperty
  a_temp_wait: assert property (p_temp_wait) else $error("temperature too early");
  property p_skip;
    conv_req.valid && !conv_req.temp |-> !(start_pin_active && conv_req.channel == 3'h7)
      && !(second_ref_active && conv_req.channel == 3'h6);
  endproperty
  a_skip: assert property (p_skip) else $error("reserved pin converted");
  c_temp: cover property ($rose(scan_busy) && scan_cfg.temp);
  c_pin: cover property ($fell(conversion_start_pin_n) && !scan_busy);
  c_rep: cover property ($rose(scan_busy) && scan_cfg.sweep == ASD_SWEEP_REP);
endmodule // asd_checker

bind asd_decoder asd_checker u_chk (.core_clk, .nrst, .cmd_valid, .cmd_byte, .conversion_start_pin_n,
  .reference_force_on, .dac_powered_up, .dac_parked_to_ref, .conv_ready, .conv_req, .scan_cfg,
  .setup_cfg, .start_pin_active, .second_ref_active, .reference_hold, .scan_busy);

// *** asd_conv_model.sv ***
/*
  Converter model that accepts requests after a set stall.
  Assumes requests change just after the rising clock edge.
*/
`timescale 1ns/100ps
module asd_conv_model (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       req_valid,
  input  wire logic [3:0] stall,
  output logic            conv_ready
);
  logic [3:0] wait_cnt;
  always @(negedge core_clk or negedge nrst) begin
    if (!nrst || !req_valid || conv_ready) begin
      wait_cnt   <= 4'h0;
      conv_ready <= 1'b0;
    end else if (wait_cnt >= stall) begin
      conv_ready <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // asd_conv_model

// *** testbench.sv ***
/*
  Testbench for the scan and setup command decoder.
  Assumes the converter model on the request side.
*/
`timescale 1ns/100ps
module testbench;
  import asd_pkg::*;
  logic           core_clk = 0, nrst = 0, cmd_valid = 0, start_n = 1, dac_up = 0, force_on = 0, parked = 0;
  logic [7:0]     cmd_byte = 8'h00;
  logic [3:0]     pair_enable = 4'h0, stall = 4'h0;
  logic [1:0]     repeat_count = 2'b00, pairing_select;
  logic           conv_ready, reference_hold, scan_busy, start_pin_active, second_ref_active;
  logic           pairing_access, temp_fresh;
  asd_conv_t      conv_req;
  asd_scan_cfg_t  scan_cfg;
  asd_setup_cfg_t setup_cfg;
  logic [3:0]     got[$];
  int             bad_count = 0, n_tests = 0, cyc, n_fresh = 0;
  always #50 core_clk = ~core_clk;
  asd_decoder DUT (.core_clk, .nrst, .cmd_valid, .cmd_byte, .conversion_start_pin_n(start_n),
    .pair_enable, .repeat_count, .reference_force_on(force_on), .dac_powered_up(dac_up),
    .dac_parked_to_ref(parked), .conv_ready, .conv_req, .scan_cfg, .setup_cfg, .pairing_select,
    .pairing_access, .start_pin_active, .second_ref_active, .reference_hold, .scan_busy, .temp_fresh);
  asd_conv_model u_conv (.core_clk, .nrst, .req_valid(conv_req.valid), .stall, .conv_ready);
  always @(posedge core_clk)
    if (conv_req.valid && conv_ready) got.push_back(conv_req.temp ? 4'h8 : {1'b0, conv_req.channel});
  // Count one-cycle fresh temperature pulses
  always @(posedge core_clk)
    if (temp_fresh) n_fresh++;
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    n_tests++;
    if (a !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_byte = b;
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  // Write a scan, wait for it to end, compare the accepted list
  task automatic run(input logic [7:0] b, input int n, input logic [31:0] e, input bit pin);
    got.delete();
    wr(b);
    if (pin) begin
      @(negedge core_clk);
      chk(scan_busy, 0);
      start_n = 1'b0;
      @(negedge core_clk);
      start_n = 1'b1;
    end
    for (cyc = 0; cyc < 400 && scan_busy !== 1'b1; cyc++) @(negedge core_clk);
    for (; cyc < 400 && scan_busy !== 1'b0; cyc++) @(negedge core_clk);
    if (cyc >= 400) begin
      bad_count++;
      give_verdict;
    end
    chk(got.size(), n);
    for (int i = 0; i < n; i++) chk(got[i], e[4*(n-1-i)+:4]);
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    chk(setup_cfg, 4'b1010);
    wr(8'h61);
    chk(setup_cfg, 4'b1000);
    chk(pairing_access, 1);
    chk(pairing_select, 2'b01);
    wr(8'h3C);
    chk(setup_cfg, 4'b1000);
    run(8'h98, 4, 32'h0000_0123, 0);
    chk(scan_cfg, 6'h18);
    run(8'hAA, 3, 32'h0000_0567, 0);
    run(8'hE6, 1, 32'h0000_0004, 0);
    chk(scan_cfg, 6'h26);
    repeat_count = 2'b01;
    stall = 4'h3;
    run(8'h94, 8, 32'h2222_2222, 0);
    stall = 4'h0;
    run(8'h97, 2, 32'h0000_0082, 0);
    chk(cyc < 188, 1);
    chk(n_fresh, 1);
    wr(8'h64);
    run(8'hB8, 7, 32'h0012_3457, 0);
    chk(second_ref_active, 1);
    pair_enable = 4'h1;
    run(8'h98, 3, 32'h0000_0023, 0);
    pair_enable = 4'h0;
    wr(8'h40);
    run(8'hA6, 1, 32'h0000_0004, 1);
    chk(start_pin_active, 1);
    wr(8'h50);
    run(8'hBE, 0, 32'h0000_0000, 1);
    wr(8'h7C);
    run(8'hAA, 2, 32'h0000_0057, 0);
    wr(8'h60);
    dac_up = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(reference_hold, 1);
    run(8'h97, 2, 32'h0000_0082, 0);
    chk(cyc > 188, 1);
    chk(n_fresh, 2);
    dac_up = 1'b0;
    force_on = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(reference_hold, 1);
    force_on = 1'b0;
    parked = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(reference_hold, 1);
    wr(8'h64);
    repeat (2) @(negedge core_clk);
    chk(reference_hold, 0);
    give_verdict;
  end
endmodule // testbench
